// ==== hdl/rcmm_top.v ====
// Remote control mode manager: mode select, defaults, halt detection
`timescale 1ns/1ps
`include "rcmm_consts.vh"
module rcmm_top #(
   parameter BRK_MIN_CYC = (`RCMM_BRK_MIN_MS * `RCMM_CLK_KHZ),
   parameter BRK_MAX_CYC = (`RCMM_BRK_MAX_MS * `RCMM_CLK_KHZ),
   parameter FIFO_DEPTH  = 4
) (
   input  wire        clk_sys_i,
   input  wire        rst_b_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire        term_conn_i,
   input  wire        rem_conn_i,
   input  wire [7:0]  rem_rx_data_i,
   input  wire        rem_rx_valid_i,
   output wire        rem_rx_ready_o,
   input  wire [7:0]  term_rx_data_i,
   input  wire        term_rx_valid_i,
   input  wire        rem_rxd_i,
   output wire        crc_mode_o,
   output wire        term_on_rem_o,
   output wire        rem_dce_o,
   output reg         halt_o,
   output wire        resp_req_o
);
   // ************************************************************
   // States
   // ************************************************************
   localparam ST_INIT = 2'h0;
   localparam ST_TERM = 2'h1;
   localparam ST_CRC  = 2'h2;

   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg  [31:0] ctrl_r;
   reg  [31:0] param_r;
   reg  [31:0] opts_r;
   reg  [31:0] times_r;
   reg  [31:0] sv_param_r;
   reg  [31:0] sv_opts_r;
   reg  [31:0] sv_times_r;
   reg         term_rem_r;
   reg         halt_esc_r;
   reg         halt_brk_r;
   reg         resp_pend_r;
   reg         exit_seen_r;
   reg         last_z_r;
   reg  [31:0] brk_cnt_r;
   reg  [31:0] brk_last_r;
   reg         init_done_r;

   wire        apb_acc;
   wire        apb_wr;
   wire        apb_rd;
   wire        in_crc;
   wire        esc_hit;
   wire        brk_hit;
   wire        fifo_in_rdy;
   wire [7:0]  fifo_dat;
   wire        fifo_vld;
   wire        fifo_pop;
   wire        rx_take;
   wire        enter_req;
   wire        do_exit;

   assign in_crc = (state_r == ST_CRC);

   // ************************************************************
   // APB slave: zero wait states
   // ************************************************************
   assign pready_o  = 1'b1;
   assign apb_acc   = psel_i & penable_i;
   assign apb_wr    = apb_acc & pwrite_i;
   assign apb_rd    = apb_acc & ~pwrite_i;
   assign pslverr_o = apb_acc & (paddr_i > `RCMM_OFF_BRKCNT);

   // ************************************************************
   // Remote character intake; only remote port feeds command mode
   // ************************************************************
   // ESC bypasses the FIFO so that a halt is never queued behind text
   assign rx_take = rem_rx_valid_i & in_crc;
   assign esc_hit = rx_take & (rem_rx_data_i == `RCMM_CHR_ESC)
                    & ~ctrl_r[`RCMM_CTRL_BIN_XFER];
   assign rem_rx_ready_o = ~in_crc | fifo_in_rdy | (rem_rx_data_i == `RCMM_CHR_ESC);

   // ************************************************************
   // BREAK timing on raw receive line (low = spacing)
   // ************************************************************
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         brk_cnt_r  <= 32'h0000_0000;
         brk_last_r <= 32'h0000_0000;
      end else if (!rem_rxd_i) begin
         if (brk_cnt_r != 32'hFFFF_FFFF)
            brk_cnt_r <= brk_cnt_r + 32'h0000_0001;
      end else begin
         if (brk_cnt_r != 32'h0000_0000)
            brk_last_r <= brk_cnt_r;
         brk_cnt_r <= 32'h0000_0000;
      end
   end
   // Judged at the line's return to marking; longer spacing is a fault
   assign brk_hit = rem_rxd_i & (brk_cnt_r >= BRK_MIN_CYC)
                    & (brk_cnt_r <= BRK_MAX_CYC) & in_crc;

   wire halt_now = esc_hit | brk_hit;

   rcmm_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH),
      .AW    (2)
   ) u_fifo (
      .clk_sys_i   (clk_sys_i),
      .rst_b_i     (rst_b_i),
      .flush_i     (halt_now | ~in_crc),
      .in_data_i   (rem_rx_data_i),
      .in_valid_i  (rx_take & (rem_rx_data_i != `RCMM_CHR_ESC)),
      .in_ready_o  (fifo_in_rdy),
      .out_data_o  (fifo_dat),
      .out_valid_o (fifo_vld),
      .out_ready_i (fifo_pop)
   );

   // Software drains characters by reading the data register
   assign fifo_pop = apb_rd & (paddr_i == `RCMM_OFF_RXDATA);
   assign do_exit  = fifo_pop & fifo_vld & (fifo_dat == `RCMM_CHR_CR) & last_z_r;

   // ************************************************************
   // Mode state machine
   // ************************************************************
   assign enter_req = apb_wr & (paddr_i == `RCMM_OFF_CTRL) & pwdata_i[`RCMM_CTRL_ENTER];

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_INIT: begin
            if (init_done_r) begin
               if (rem_conn_i & (ctrl_r[`RCMM_CTRL_PWRUP_CRC] |
                   (~ctrl_r[`RCMM_CTRL_MENU_REM] & ~term_conn_i)))
                  state_nxt = ST_CRC;
               else
                  state_nxt = ST_TERM;
            end
         end
         ST_TERM: begin
            if (enter_req & rem_conn_i)
               state_nxt = ST_CRC;
         end
         ST_CRC: begin
            if (do_exit)
               state_nxt = ST_TERM;
         end
         default: state_nxt = ST_INIT;
      endcase
   end

   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r     <= ST_INIT;
         init_done_r <= 1'b0;
         term_rem_r  <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         init_done_r <= 1'b1;
         term_rem_r  <= ctrl_r[`RCMM_CTRL_MENU_REM] & rem_conn_i;
      end
   end

   // ************************************************************
   // Parameters: save and load defaults on entry, restore on exit
   // ************************************************************
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         param_r    <= `RCMM_PARAM_RST;
         opts_r     <= `RCMM_OPTS_RST;
         times_r    <= `RCMM_TIMES_RST;
         sv_param_r <= `RCMM_PARAM_RST;
         sv_opts_r  <= `RCMM_OPTS_RST;
         sv_times_r <= `RCMM_TIMES_RST;
      end else if (state_r != ST_CRC && state_nxt == ST_CRC) begin
         sv_param_r <= param_r;
         sv_opts_r  <= opts_r;
         sv_times_r <= times_r;
         param_r    <= `RCMM_PARAM_CRC;
         opts_r     <= `RCMM_OPTS_CRC;
         times_r    <= `RCMM_TIMES_CRC;
      end else if (do_exit) begin
         param_r <= sv_param_r;
         opts_r  <= sv_opts_r;
         times_r <= sv_times_r;
      end else if (apb_wr) begin
         case (paddr_i)
            `RCMM_OFF_PARAM: param_r <= pwdata_i;
            `RCMM_OFF_OPTS:  opts_r  <= pwdata_i;
            `RCMM_OFF_TIMES: times_r <= pwdata_i;
            default: ;
         endcase
      end
   end

   // ************************************************************
   // Control, halt flags and response tracking
   // ************************************************************
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_r      <= `RCMM_CTRL_RST;
         halt_esc_r  <= 1'b0;
         halt_brk_r  <= 1'b0;
         halt_o      <= 1'b0;
         resp_pend_r <= 1'b0;
         last_z_r    <= 1'b0;
         exit_seen_r <= 1'b0;
      end else begin
         halt_o <= halt_now;
         if (apb_wr && paddr_i == `RCMM_OFF_CTRL)
            ctrl_r <= pwdata_i & 32'h0000_003B;
         else if (halt_now)
            ctrl_r[`RCMM_CTRL_OP_BUSY] <= 1'b0;
         if (brk_hit)
            ctrl_r[`RCMM_CTRL_BIN_XFER] <= 1'b0;
         // Set wins over a software clear in the same cycle
         if (esc_hit)
            halt_esc_r <= 1'b1;
         else if (apb_wr && paddr_i == `RCMM_OFF_STATUS && pwdata_i[`RCMM_ST_HALT_ESC])
            halt_esc_r <= 1'b0;
         if (brk_hit)
            halt_brk_r <= 1'b1;
         else if (apb_wr && paddr_i == `RCMM_OFF_STATUS && pwdata_i[`RCMM_ST_HALT_BRK])
            halt_brk_r <= 1'b0;
         if (halt_now)
            last_z_r <= 1'b0;
         else if (fifo_pop & fifo_vld)
            last_z_r <= (fifo_dat == `RCMM_CHR_EXIT);
         // A line end other than the exit command owes exactly one response, written to RESP
         if (fifo_pop & fifo_vld & (fifo_dat == `RCMM_CHR_CR) & ~do_exit)
            resp_pend_r <= 1'b1;
         else if ((apb_wr && paddr_i == `RCMM_OFF_RESP) || halt_now || !in_crc)
            resp_pend_r <= 1'b0;
         if (do_exit)
            exit_seen_r <= 1'b1;
         else if (enter_req)
            exit_seen_r <= 1'b0;
      end
   end

   assign crc_mode_o    = in_crc;
   assign term_on_rem_o = (state_r == ST_TERM) & term_rem_r;
   assign rem_dce_o     = ctrl_r[`RCMM_CTRL_REM_DCE];
   assign resp_req_o    = resp_pend_r;

   // ************************************************************
   // Read mux
   // ************************************************************
   always @* begin
      prdata_o = 32'h0000_0000;
      if (apb_rd) begin
         case (paddr_i)
            `RCMM_OFF_CTRL:   prdata_o = ctrl_r;
            `RCMM_OFF_STATUS: prdata_o = {25'h0000000, exit_seen_r, fifo_vld,
                                          ctrl_r[`RCMM_CTRL_OP_BUSY], halt_brk_r,
                                          halt_esc_r, term_on_rem_o, in_crc};
            `RCMM_OFF_PARAM:  prdata_o = param_r;
            `RCMM_OFF_OPTS:   prdata_o = opts_r;
            `RCMM_OFF_TIMES:  prdata_o = times_r;
            `RCMM_OFF_RXDATA: prdata_o = {23'h000000, fifo_vld, fifo_dat};
            `RCMM_OFF_RESP:   prdata_o = {31'h00000000, resp_pend_r};
            `RCMM_OFF_BRKCNT: prdata_o = brk_last_r;
            default:          prdata_o = 32'h0000_0000;
         endcase
      end
   end
endmodule // rcmm_top

// ==== include/rcmm_consts.vh ====
// Constants for the remote control mode manager
`ifndef RCMM_CONSTS_VH
`define RCMM_CONSTS_VH

// ************************************************************
// APB register byte offsets
// ************************************************************
`define RCMM_OFF_CTRL      12'h000
`define RCMM_OFF_STATUS    12'h004
`define RCMM_OFF_PARAM     12'h008
`define RCMM_OFF_OPTS      12'h00C
`define RCMM_OFF_TIMES     12'h010
`define RCMM_OFF_RXDATA    12'h014
`define RCMM_OFF_RESP      12'h018
`define RCMM_OFF_BRKCNT    12'h01C

// ************************************************************
// Control register fields
// ************************************************************
`define RCMM_CTRL_PWRUP_CRC   0
`define RCMM_CTRL_MENU_REM    1
`define RCMM_CTRL_ENTER       2
`define RCMM_CTRL_BIN_XFER    3
`define RCMM_CTRL_OP_BUSY     4
`define RCMM_CTRL_REM_DCE     5
`define RCMM_CTRL_RST         32'h0000_0000

// ************************************************************
// Status register fields
// ************************************************************
`define RCMM_ST_CRC        0
`define RCMM_ST_TERM_REM   1
`define RCMM_ST_HALT_ESC   2
`define RCMM_ST_HALT_BRK   3
`define RCMM_ST_BUSY       4
`define RCMM_ST_RX_VALID   5
`define RCMM_ST_EXIT       6

// ************************************************************
// Parameter register: 0..7 format, 8..9 instr code, 10..11 verify,
// 12 xfer port remote, 13 source ram, 14 fuse data, 15 fuse prog,
// 16..23 nulls, 24 prog mode set, 25 autoinc, 26 up eof, 27 dn eof,
// 28..31 set size
// ************************************************************
// Options register: 0 continuity, 1 signature, 2 byte swap, 3 ram fill,
// 4 illegal bit, 5 pin translate, 6 logic verify all, 7 commercial reject,
// 8 blank check, 9 yield tally, 10 bulk erase, 11 host command set
// Times register: 0..7 I/O timeout seconds, 8..15 upload wait seconds
// ************************************************************
`define RCMM_PARAM_CRC     32'h10FF_3851
`define RCMM_OPTS_CRC      32'h0000_00E3
`define RCMM_TIMES_CRC     32'h0000_001E
`define RCMM_PARAM_RST     32'h0000_0000
`define RCMM_OPTS_RST      32'h0000_0000
`define RCMM_TIMES_RST     32'h0000_0000

// ************************************************************
// Characters and timing
// ************************************************************
`define RCMM_CHR_ESC       8'h1B
`define RCMM_CHR_EXIT      8'h5A
`define RCMM_CHR_CR        8'h0D
`define RCMM_BRK_MIN_MS    110
`define RCMM_BRK_MAX_MS    700
`define RCMM_CLK_KHZ       200000
`endif

// ==== hdl/rcmm_fifo.v ====
// Small flip-flop FIFO for received command characters
`timescale 1ns/1ps
module rcmm_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk_sys_i,
   input  wire             rst_b_i,
   input  wire             flush_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0]    wp_r;
   reg [AW-1:0]    rp_r;
   reg [AW:0]      cnt_r;
   wire            push;
   wire            pop;
   integer         i;

   assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
   assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
   assign out_data_o  = mem_r[rp_r];
   assign push        = in_valid_i & in_ready_o & ~flush_i;
   assign pop         = out_valid_o & out_ready_i & ~flush_i;

   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1)
            mem_r[i] <= {WIDTH{1'b0}};
      end else if (flush_i) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data_i;
            wp_r        <= wp_r + 1'b1;
         end
         if (pop)
            rp_r <= rp_r + 1'b1;
         if (push & ~pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & ~push)
            cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule // rcmm_fifo

// ==== tb/rcmm_chk.sv ====
// Port checker for the remote control mode manager
`timescale 1ns/1ps
module rcmm_chk #(
   parameter BRK_MIN_CYC = 20,
   parameter BRK_MAX_CYC = 100
) (
   input wire        clk_sys_i,
   input wire        rst_b_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire [11:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire [7:0]  rem_rx_data_i,
   input wire        rem_rx_valid_i,
   input wire        rem_rx_ready_o,
   input wire        rem_rxd_i,
   input wire        crc_mode_o,
   input wire        term_on_rem_o,
   input wire        halt_o
);
   reg         rxd_d_r;
   reg  [31:0] spc_r;
   wire        rise_w;
   wire        esc_w;
   assign rise_w = rem_rxd_i & ~rxd_d_r;
   assign esc_w  = crc_mode_o & rem_rx_valid_i & rem_rx_ready_o & (rem_rx_data_i == 8'h1B);
   // Spacing length, held through the cycle the line returns to mark
   always @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rxd_d_r <= 1'b1;
         spc_r   <= 32'h0;
      end else begin
         rxd_d_r <= rem_rxd_i;
         spc_r   <= rem_rxd_i ? 32'h0 : spc_r + 32'h1;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // ************************************************************
   // Assertions
   // ************************************************************
   // One cycle of slack on each bound for edge counting; BREAK only counts in command mode
   sequence brk_long_s;
      crc_mode_o && rise_w && spc_r > BRK_MIN_CYC && spc_r < BRK_MAX_CYC;
   endsequence
   sequence brk_short_s;
      rise_w && spc_r + 1 < BRK_MIN_CYC && !esc_w;
   endsequence
   pready_high_a: assert property (pready_o) else $error("pready low");
   slverr_range_a: assert property (psel_i && penable_i |-> pslverr_o == (paddr_i > 12'h01C))
      else $error("pslverr wrong");
   rdata_idle_a: assert property (!(psel_i && penable_i) |-> prdata_o == 32'h0) else $error("prdata not 0");
   halt_cause_a: assert property (halt_o |-> $past(esc_w) || $past(rise_w) || $past(rise_w, 2))
      else $error("halt without cause");
   halt_pulse_a: assert property (halt_o |=> !halt_o) else $error("halt too long");
   ready_idle_a: assert property (!crc_mode_o |-> rem_rx_ready_o) else $error("ready low idle");
   esc_ready_a: assert property (crc_mode_o && rem_rx_data_i == 8'h1B |-> rem_rx_ready_o)
      else $error("escape refused");
   mode_excl_a: assert property (crc_mode_o |-> !term_on_rem_o) else $error("both modes");
   brk_halt_a: assert property (brk_long_s |-> ##[1:2] halt_o) else $error("break missed");
   brk_short_a: assert property (brk_short_s |=> !halt_o) else $error("short spacing halted");
endmodule // rcmm_chk

// ==== tb/rcmm_host.sv ====
// Host computer model on the remote serial side
`timescale 1ns/1ps
module rcmm_host (
   input  wire       clk_sys_i,
   output reg  [7:0] rem_rx_data_o,
   output reg        rem_rx_valid_o,
   input  wire       rem_rx_ready_i,
   output reg        rem_rxd_o
);
   initial begin
      rem_rx_data_o  = 8'h00;
      rem_rx_valid_o = 1'b0;
      rem_rxd_o      = 1'b1;
   end
   // One character of a single-line command, held for one edge and then until ready is seen high
   task send_char(input [7:0] c);
      begin
         rem_rx_data_o  <= c;
         rem_rx_valid_o <= 1'b1;
         @(posedge clk_sys_i);
         while (rem_rx_ready_i !== 1'b1) @(posedge clk_sys_i);
         rem_rx_valid_o <= 1'b0;
         // Stale byte inverted so nothing can pass for a repeat
         rem_rx_data_o  <= ~c;
         @(posedge clk_sys_i);
      end
   endtask
   // Line in spacing state for n cycles, then back to mark
   task send_break(input integer n);
      begin
         rem_rxd_o <= 1'b0;
         repeat (n) @(posedge clk_sys_i);
         rem_rxd_o <= 1'b1;
         @(posedge clk_sys_i);
      end
   endtask
endmodule // rcmm_host

// ==== tb/tb.sv ====
// Testbench for the remote control mode manager
`timescale 1ns/1ps
`include "rcmm_consts.vh"
module tb;
   reg         clk_sys_i, rst_b_i, psel, penable, pwrite, tconn, rconn, tvld, slv_q;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd_q;
   reg  [7:0]  tdat;
   wire [31:0] prdata;
   wire [7:0]  rx_dat;
   wire        pready, pslverr, rx_vld, rx_rdy, rxd, crc, tor, dce, halt, resp;
   integer     n_errors, n_checks, n_halt;
   rcmm_top #(.BRK_MIN_CYC(20), .BRK_MAX_CYC(100), .FIFO_DEPTH(4)) dut (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .term_conn_i(tconn), .rem_conn_i(rconn), .rem_rx_data_i(rx_dat), .rem_rx_valid_i(rx_vld),
      .rem_rx_ready_o(rx_rdy), .term_rx_data_i(tdat), .term_rx_valid_i(tvld), .rem_rxd_i(rxd),
      .crc_mode_o(crc), .term_on_rem_o(tor), .rem_dce_o(dce), .halt_o(halt), .resp_req_o(resp));
   rcmm_host host (.clk_sys_i(clk_sys_i), .rem_rx_data_o(rx_dat), .rem_rx_valid_o(rx_vld),
      .rem_rx_ready_i(rx_rdy), .rem_rxd_o(rxd));
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) if (halt === 1'b1) n_halt = n_halt + 1;
   // ************************************************************
   // Tasks
   // ************************************************************
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         cyc(1);
         penable <= 1'b1;
         cyc(1);
         while (pready !== 1'b1) cyc(1);
         rd_q = prdata;
         slv_q = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         cyc(1);
      end
   endtask
   task rdm(input string nm, input [11:0] a, input [31:0] m, input [31:0] exp);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, rd_q & m, exp);
      end
   endtask
   task close_out;
      begin
         $display("checks %0d errors %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      #50000;
      n_errors = n_errors + 1;
      close_out;
   end
   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      {n_errors, n_checks, n_halt} = 0;
      {psel, penable, pwrite, paddr, pwdata, tvld, tdat, rst_b_i} = 0;
      {tconn, rconn} = 2'b11;
      cyc(2);
      rst_b_i <= 1'b1;
      cyc(4);
      chk("crc mode", crc, 0);
      chk("term on remote", tor, 0);
      apb(1'b1, `RCMM_OFF_CTRL, 32'h22);
      cyc(1);
      chk("term on remote", tor, 1);
      chk("dce", dce, 1);
      apb(1'b1, `RCMM_OFF_PARAM, 32'h1234_5678);
      apb(1'b1, `RCMM_OFF_OPTS, 32'h5);
      apb(1'b1, `RCMM_OFF_TIMES, 32'h7);
      apb(1'b0, 12'h020, 32'h0);
      chk("slverr", slv_q, 1);
      apb(1'b1, `RCMM_OFF_CTRL, 32'h04);
      chk("crc mode", crc, 1);
      rdm("param", `RCMM_OFF_PARAM, 32'hFFFF_FFFF, 32'h10FF_3851);
      rdm("opts", `RCMM_OFF_OPTS, 32'hFFFF_FFFF, 32'h0000_00E3);
      rdm("times", `RCMM_OFF_TIMES, 32'hFFFF_FFFF, 32'h0000_001E);
      host.send_char(8'h48);
      host.send_char(`RCMM_CHR_CR);
      rdm("rx", `RCMM_OFF_RXDATA, 32'h1FF, 32'h148);
      rdm("rx", `RCMM_OFF_RXDATA, 32'h1FF, 32'h10D);
      chk("resp req", resp, 1);
      apb(1'b1, `RCMM_OFF_RESP, 32'h0);
      chk("resp req", resp, 0);
      tdat <= `RCMM_CHR_ESC;
      tvld <= 1'b1;
      cyc(1);
      tvld <= 1'b0;
      cyc(3);
      chk("halts", n_halt, 0);
      apb(1'b1, `RCMM_OFF_CTRL, 32'h10);
      for (int i = 0; i < 4; i++) host.send_char(8'h41 + i[7:0]);
      chk("rx ready full", rx_rdy, 0);
      host.send_char(`RCMM_CHR_ESC);
      cyc(1);
      chk("halts", n_halt, 1);
      rdm("status", `RCMM_OFF_STATUS, 32'h14, 32'h04);
      rdm("rx", `RCMM_OFF_RXDATA, 32'h100, 32'h0);
      apb(1'b1, `RCMM_OFF_STATUS, 32'h0C);
      apb(1'b1, `RCMM_OFF_CTRL, 32'h08);
      host.send_char(`RCMM_CHR_ESC);
      cyc(2);
      chk("halts", n_halt, 1);
      host.send_break(10);
      cyc(4);
      chk("halts", n_halt, 1);
      host.send_break(50);
      cyc(4);
      chk("halts", n_halt, 2);
      rdm("status", `RCMM_OFF_STATUS, 32'h08, 32'h08);
      rdm("break length", `RCMM_OFF_BRKCNT, 32'hFFFF_FFFF, 32'h0000_0032);
      apb(1'b1, `RCMM_OFF_CTRL, 32'h0);
      host.send_char(`RCMM_CHR_EXIT);
      host.send_char(`RCMM_CHR_CR);
      rdm("rx", `RCMM_OFF_RXDATA, 32'h1FF, 32'h15A);
      rdm("rx", `RCMM_OFF_RXDATA, 32'h1FF, 32'h10D);
      cyc(2);
      chk("crc mode", crc, 0);
      rdm("param", `RCMM_OFF_PARAM, 32'hFFFF_FFFF, 32'h1234_5678);
      rdm("opts", `RCMM_OFF_OPTS, 32'hFFFF_FFFF, 32'h5);
      rdm("times", `RCMM_OFF_TIMES, 32'hFFFF_FFFF, 32'h7);
      rdm("status", `RCMM_OFF_STATUS, 32'h43, 32'h40);
      rst_b_i <= 1'b0;
      tconn <= 1'b0;
      cyc(2);
      rst_b_i <= 1'b1;
      cyc(4);
      chk("crc mode", crc, 1);
      rst_b_i <= 1'b0;
      tconn <= 1'b1;
      rconn <= 1'b0;
      cyc(2);
      rst_b_i <= 1'b1;
      cyc(4);
      chk("crc mode", crc, 0);
      apb(1'b1, `RCMM_OFF_CTRL, 32'h04);
      chk("crc mode", crc, 0);
      close_out;
   end
endmodule // tb
bind rcmm_top rcmm_chk #(.BRK_MIN_CYC(BRK_MIN_CYC), .BRK_MAX_CYC(BRK_MAX_CYC)) u_chk (.clk_sys_i, .rst_b_i,
   .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .rem_rx_data_i, .rem_rx_valid_i,
   .rem_rx_ready_o, .rem_rxd_i, .crc_mode_o, .term_on_rem_o, .halt_o);
